// file: secp_consts.svh
// Opcodes, status bit positions, reset values and timing counts
`ifndef SECP_CONSTS_SVH
`define SECP_CONSTS_SVH

`define SECP_OP_LATCH_SET    8'h06
`define SECP_OP_LATCH_CLEAR  8'h04
`define SECP_OP_STATUS_READ  8'h05
`define SECP_OP_STATUS_WRITE 8'h01
`define SECP_OP_ARRAY_READ   8'h03
`define SECP_OP_ARRAY_WRITE  8'h02

`define SECP_BIT_BUSY        0
`define SECP_BIT_LATCH       1
`define SECP_BIT_BP_LO       2
`define SECP_BIT_BP_HI       3
`define SECP_BIT_LOCK        7

`define SECP_NV_RESET        3'h0

`define SECP_BP_NONE         2'h0
`define SECP_BP_QUARTER      2'h1
`define SECP_BP_HALF         2'h2
`define SECP_BP_WHOLE        2'h3

`define SECP_BITS_OPCODE     16'h0008
`define SECP_BITS_STATUS_WR  16'h0010
`define SECP_BITS_ARRAY_MIN  16'h0028
`define SECP_BITS_CAPTURE    16'h0020

`define SECP_WRITE_TIME_US   100
`define SECP_CLK_MHZ         20
`define SECP_WRITE_CYCLES    (`SECP_WRITE_TIME_US * `SECP_CLK_MHZ)

`endif

// file: secp_pkg.sv
// Types shared by the command and status block
package secp_pkg;

  typedef enum logic [1:0] {
    SECP_IDLE,
    SECP_STATUS_CYCLE,
    SECP_ARRAY_CYCLE
  } secp_cycle_e;

  typedef struct packed {
    logic        lock;
    logic [2:0]  zero;
    logic        bp_hi;
    logic        bp_lo;
    logic        latch;
    logic        busy;
  } secp_status_s;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [15:0] count;
    logic [31:0] bits;
    logic        dropped;
  } secp_frame_s;

  typedef struct packed {
    logic        go;
    logic [16:0] addr;
  } secp_array_req_s;

endpackage

// file: secp_sync.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none

module secp_sync #(
  parameter int         WIDTH = 1,
  parameter logic [7:0] INIT  = 8'h00
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= INIT[WIDTH-1:0];
      q      <= INIT[WIDTH-1:0];
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

`default_nettype wire

// file: secp_core.sv
// Serial EEPROM opcode decoder, status register and write protection
`timescale 1ns/10ps
`default_nettype none
`include "secp_consts.svh"

module secp_core #(
  parameter int WRITE_CYCLES = `SECP_WRITE_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          spi_sck,
  input  wire logic          spi_cs_n,
  input  wire logic          spi_mosi,
  output logic               spi_miso_o,
  output logic               spi_miso_oe_n,
  input  wire logic          wp_n,
  output secp_pkg::secp_array_req_s array_write,
  output logic               array_read_go,
  output logic               write_done,
  output logic               busy,
  output logic               hw_lock,
  output logic [7:0]         status_out,
  output logic               cmd_refused
);

  localparam logic [23:0] CYCLES_LAST = 24'(WRITE_CYCLES - 1);

  // Protect range check on a 17-bit array address
  function automatic logic addr_protected(input logic [1:0] bp, input logic [16:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (bp)
      `SECP_BP_NONE:    hit = 1'b0;
      `SECP_BP_QUARTER: hit = addr[16] & addr[15];
      `SECP_BP_HALF:    hit = addr[16];
      `SECP_BP_WHOLE:   hit = 1'b1;
    endcase
    return hit;
  endfunction

  // Opcode membership test
  function automatic logic opcode_known(input logic [7:0] op);
    logic ok;
    ok = (op == `SECP_OP_LATCH_SET)    ||
         (op == `SECP_OP_LATCH_CLEAR)  ||
         (op == `SECP_OP_STATUS_READ)  ||
         (op == `SECP_OP_STATUS_WRITE) ||
         (op == `SECP_OP_ARRAY_READ)   ||
         (op == `SECP_OP_ARRAY_WRITE);
    return ok;
  endfunction

  // ---------------- Link domain (serial clock) ----------------

  secp_pkg::secp_frame_s frame_r;
  logic                  armed_r;
  logic [7:0]            out_sh_r;
  logic                  drive_r;
  logic [7:0]            status_link;
  logic [15:0]           cnt_now;
  logic [31:0]           bits_now;

  // Count restarts at the first edge of every selection
  assign cnt_now  = armed_r ? 16'h0000 : frame_r.count;
  assign bits_now = armed_r ? 32'h0000_0000 : frame_r.bits;

  // Armed while deselected or in reset; the frame's first clock ends it
  always_ff @(posedge spi_sck or posedge spi_cs_n or posedge rst) begin
    if (rst || spi_cs_n) begin
      armed_r <= 1'b1;
    end else begin
      armed_r <= 1'b0;
    end
  end

  // Input bits sampled on rising clock
  always_ff @(posedge spi_sck or posedge rst) begin
    if (rst) begin
      frame_r <= '0;
    end else begin
      if (cnt_now != 16'hFFFF) begin
        frame_r.count <= cnt_now + 16'h0001;
      end else begin
        frame_r.count <= cnt_now;
      end
      if (cnt_now < `SECP_BITS_CAPTURE) begin
        frame_r.bits <= {bits_now[30:0], spi_mosi};
      end else begin
        frame_r.bits <= bits_now;
      end
      if (cnt_now == (`SECP_BITS_OPCODE - 16'h0001)) begin
        frame_r.opcode  <= {bits_now[6:0], spi_mosi};
        frame_r.dropped <= !opcode_known({bits_now[6:0], spi_mosi});
      end else if (armed_r) begin
        frame_r.opcode  <= 8'h00;
        frame_r.dropped <= 1'b0;
      end
    end
  end

  secp_sync #(
    .WIDTH (8),
    .INIT  (8'h00)
  ) u_status_link (
    .clk (spi_sck),
    .rst (rst),
    .d   (status_out),
    .q   (status_link)
  );

  // Status byte reloaded at every byte boundary, MSB first; deselect releases
  always_ff @(negedge spi_sck or posedge rst or posedge spi_cs_n) begin
    if (rst || spi_cs_n) begin
      out_sh_r   <= 8'h00;
      spi_miso_o <= 1'b0;
      drive_r    <= 1'b0;
    end else if (armed_r) begin
      out_sh_r   <= 8'h00;
      spi_miso_o <= 1'b0;
      drive_r    <= 1'b0;
    end else if (frame_r.opcode == `SECP_OP_STATUS_READ && !frame_r.dropped &&
                 frame_r.count >= `SECP_BITS_OPCODE && frame_r.count[2:0] == 3'h0) begin
      out_sh_r   <= {status_link[6:0], 1'b0};
      spi_miso_o <= status_link[7];
      drive_r    <= 1'b1;
    end else begin
      out_sh_r   <= {out_sh_r[6:0], 1'b0};
      spi_miso_o <= out_sh_r[7];
    end
  end

  // Output released when deselected or after an unknown opcode
  assign spi_miso_oe_n = !(drive_r && !spi_cs_n && !frame_r.dropped);

  // ---------------- Core domain ----------------

  logic                   cs_n_s;
  logic                   wp_n_s;
  logic                   cs_n_d_r;
  logic                   cs_rise;
  secp_pkg::secp_cycle_e  cycle_r;
  logic [23:0]            timer_r;
  logic                   latch_r;
  logic                   lock_r;
  logic [1:0]             bp_r;
  logic                   lock_pend_r;
  logic [1:0]             bp_pend_r;
  logic                   cycle_end;
  logic                   is_busy;
  logic [7:0]             f_op;
  logic [15:0]            f_cnt;
  logic [16:0]            f_addr;
  logic                   f_ok;
  logic                   do_latch_set;
  logic                   do_latch_clear;
  logic                   do_status_wr;
  logic                   do_array_wr;
  logic                   do_array_rd;
  logic                   req_refused;

  secp_sync #(
    .WIDTH (1),
    .INIT  (8'h01)
  ) u_cs_sync (
    .clk (clk),
    .rst (rst),
    .d   (spi_cs_n),
    .q   (cs_n_s)
  );

  secp_sync #(
    .WIDTH (1),
    .INIT  (8'h01)
  ) u_wp_sync (
    .clk (clk),
    .rst (rst),
    .d   (wp_n),
    .q   (wp_n_s)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_n_d_r <= 1'b1;
    end else begin
      cs_n_d_r <= cs_n_s;
    end
  end

  // Frame fields are still while deselected, so reading them here is safe
  assign cs_rise = cs_n_s && !cs_n_d_r;
  assign f_op    = frame_r.opcode;
  assign f_cnt   = frame_r.count;
  assign f_addr  = frame_r.bits[16:0];
  assign f_ok    = cs_rise && !frame_r.dropped && f_cnt >= `SECP_BITS_OPCODE;
  assign is_busy = cycle_r != secp_pkg::SECP_IDLE;

  // Lock mode follows the pin and the bit in either order
  assign hw_lock = lock_r && !wp_n_s;

  assign do_latch_set   = f_ok && !is_busy && f_op == `SECP_OP_LATCH_SET &&
                          f_cnt == `SECP_BITS_OPCODE;
  assign do_latch_clear = f_ok && !is_busy && f_op == `SECP_OP_LATCH_CLEAR &&
                          f_cnt == `SECP_BITS_OPCODE;
  assign do_status_wr   = f_ok && !is_busy && f_op == `SECP_OP_STATUS_WRITE &&
                          f_cnt == `SECP_BITS_STATUS_WR && latch_r &&
                          !hw_lock;
  assign do_array_wr    = f_ok && !is_busy && f_op == `SECP_OP_ARRAY_WRITE &&
                          f_cnt >= `SECP_BITS_ARRAY_MIN && f_cnt[2:0] == 3'h0 &&
                          latch_r && !addr_protected(bp_r, f_addr);
  assign do_array_rd    = f_ok && !is_busy && f_op == `SECP_OP_ARRAY_READ &&
                          f_cnt >= `SECP_BITS_CAPTURE;
  assign req_refused    = f_ok && f_op != `SECP_OP_STATUS_READ &&
                          !(do_latch_set || do_latch_clear || do_status_wr ||
                            do_array_wr || do_array_rd);

  assign cycle_end = is_busy && timer_r == CYCLES_LAST;

  // Self-timed write cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cycle_r <= secp_pkg::SECP_IDLE;
      timer_r <= 24'h00_0000;
    end else begin
      unique case (cycle_r)
        secp_pkg::SECP_IDLE: begin
          timer_r <= 24'h00_0000;
          if (do_status_wr) begin
            cycle_r <= secp_pkg::SECP_STATUS_CYCLE;
          end else if (do_array_wr) begin
            cycle_r <= secp_pkg::SECP_ARRAY_CYCLE;
          end
        end
        secp_pkg::SECP_STATUS_CYCLE,
        secp_pkg::SECP_ARRAY_CYCLE: begin
          if (cycle_end) begin
            cycle_r <= secp_pkg::SECP_IDLE;
            timer_r <= 24'h00_0000;
          end else begin
            timer_r <= timer_r + 24'h00_0001;
          end
        end
        default: begin
          cycle_r <= secp_pkg::SECP_IDLE;
          timer_r <= 24'h00_0000;
        end
      endcase
    end
  end

  // Write latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_r <= 1'b0;
    end else if (do_latch_set) begin
      latch_r <= 1'b1;
    end else if (do_latch_clear || cycle_end) begin
      latch_r <= 1'b0;
    end
  end

  // New protect values held aside until the cycle ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_pend_r <= 1'b0;
      bp_pend_r   <= 2'h0;
    end else if (do_status_wr) begin
      lock_pend_r <= frame_r.bits[`SECP_BIT_LOCK];
      bp_pend_r   <= {frame_r.bits[`SECP_BIT_BP_HI], frame_r.bits[`SECP_BIT_BP_LO]};
    end
  end

  // Non-volatile bits, delivery value at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {lock_r, bp_r} <= `SECP_NV_RESET;
    end else if (cycle_end && cycle_r == secp_pkg::SECP_STATUS_CYCLE) begin
      lock_r <= lock_pend_r;
      bp_r   <= bp_pend_r;
    end
  end

  // Array side requests and completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      array_write   <= '0;
      array_read_go <= 1'b0;
      write_done    <= 1'b0;
      cmd_refused   <= 1'b0;
    end else begin
      array_write.go <= do_array_wr;
      if (do_array_wr) begin
        array_write.addr <= f_addr;
      end
      array_read_go <= do_array_rd;
      write_done    <= cycle_end;
      cmd_refused   <= req_refused;
    end
  end

  // Status image, b6..b4 zero; busy clears with the new latch and protect bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_out <= 8'h00;
      busy       <= 1'b0;
    end else begin
      status_out[`SECP_BIT_BUSY]  <= is_busy;
      status_out[`SECP_BIT_LATCH] <= latch_r;
      status_out[`SECP_BIT_BP_LO] <= bp_r[0];
      status_out[`SECP_BIT_BP_HI] <= bp_r[1];
      status_out[6:4]             <= 3'h0;
      status_out[`SECP_BIT_LOCK]  <= lock_r;
      busy                        <= is_busy;
    end
  end

endmodule

`default_nettype wire

// file: secp_core_properties.sv
// Concurrent checks on the command and status block ports
`timescale 1ns/10ps
`default_nettype none
module secp_core_properties #(
  parameter int WRITE_CYCLES = 2000
) (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      spi_cs_n,
  input wire logic                      spi_miso_oe_n,
  input wire logic                      wp_n,
  input wire secp_pkg::secp_array_req_s array_write,
  input wire logic                      write_done,
  input wire logic                      busy,
  input wire logic                      hw_lock,
  input wire logic [7:0]                status_out,
  input wire logic                      cmd_refused
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int busy_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy ? busy_cnt + 1 : 0;
    end
  end
  sequence pin_high_s;
    wp_n [*4];
  endsequence
  sequence pin_low_s;
    !wp_n [*4];
  endsequence
  zero_bits_a: assert property (status_out[6:4] == 3'h0)
    else $error("status b6..b4 not zero");
  pin_unlock_a: assert property (pin_high_s |-> !hw_lock)
    else $error("lock mode with pin high");
  pin_lock_a: assert property (pin_low_s ##0 status_out[7] |-> hw_lock)
    else $error("lock mode missing");
  lock_image_a: assert property (hw_lock && $past(hw_lock) |-> status_out[7])
    else $error("lock bit image wrong");
  busy_length_a: assert property ($fell(busy) |-> $past(busy_cnt) + 2 >= WRITE_CYCLES
    && $past(busy_cnt) <= WRITE_CYCLES) else $error("busy length wrong");
  start_latch_a: assert property ($rose(busy) |-> $past(status_out[1]))
    else $error("write started without latch");
  latch_deselect_a: assert property ($rose(status_out[1]) |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("latch set while selected");
  nv_at_end_a: assert property ($changed(status_out[7:2]) |-> $fell(status_out[0]))
    else $error("protect bits changed mid cycle");
  done_clears_a: assert property (write_done |-> ##[0:2] status_out[1:0] == 2'h0)
    else $error("busy or latch not cleared");
  release_a: assert property (spi_cs_n |-> spi_miso_oe_n)
    else $error("data out driven while deselected");
  refuse_go_a: assert property (cmd_refused |-> !array_write.go)
    else $error("refused write issued");
endmodule
`default_nettype wire

// file: secp_spi_master.sv
// Serial bus master model for the command block
`timescale 1ns/10ps
`default_nettype none
module secp_spi_master (
  output logic     sck,
  output logic     cs_n,
  output logic     mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  logic cpol = 1'b0;
  logic last = 1'b0;
  wire logic miso = miso_oe_n ? ~last : miso_o;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Bits change with clock low, sampled on rising edge
  task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    sck = cpol;
    #20 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #32 sck = 1'b0;
      mosi = d[i];
      #32 sck = 1'b1;
      q = {q[6:0], miso};
      last = miso;
    end
    // Deselect before the next rising edge
    #16 sck = cpol;
    #16 cs_n = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// file: spi_eeprom_cmd_status_protect_tb.sv
// Self-checking bench for the command, status and protection block
`timescale 1ns/10ps
`default_nettype none
module spi_eeprom_cmd_status_protect_tb;
  logic                      clk = 1'b0;
  logic                      rst = 1'b0;
  logic                      wp_n = 1'b1;
  wire logic                 sck, cs_n, mosi, miso_o, miso_oe_n;
  secp_pkg::secp_array_req_s aw;
  logic                      rgo, wdone, busy, hw_lock, refd;
  logic [7:0]                st, s, e, d, q;
  logic [16:0]               a;
  int                        fails = 0, n_tests = 0, n_go = 0, n_ref = 0, n_rg = 0, g, r;
  logic                      p;
  always #25 clk = ~clk;
  secp_core #(.WRITE_CYCLES(200)) secp_core_inst (.clk(clk), .rst(rst), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe_n(miso_oe_n),
    .wp_n(wp_n), .array_write(aw), .array_read_go(rgo), .write_done(wdone), .busy(busy),
    .hw_lock(hw_lock), .status_out(st), .cmd_refused(refd));
  secp_spi_master secp_spi_master_inst (.sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n));
  always @(posedge clk) begin
    if (aw.go === 1'b1) n_go <= n_go + 1;
    if (refd === 1'b1) n_ref <= n_ref + 1;
    if (rgo === 1'b1) n_rg <= n_rg + 1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fr(input logic [39:0] v, input int n);
    secp_spi_master_inst.xfer(v, n, q);
  endtask
  task automatic rd_st;
    secp_spi_master_inst.xfer(40'h0500, 16, s);
  endtask
  // Polls busy through status reads
  task automatic wait_idle;
    for (int i = 0; i < 40; i++) begin
      rd_st();
      if (s[0] === 1'b0) return;
    end
    fails++;
    give_verdict();
  endtask
  task automatic status_update_cmd(input logic [7:0] v);
    fr(40'h06, 8);
    fr({24'h0, 8'h01, v}, 16);
  endtask
  function automatic logic prot(input logic [1:0] bp, input logic [16:0] ad);
    return bp == 2'h3 || (bp == 2'h2 && ad[16]) || (bp == 2'h1 && ad[16:15] == 2'h3);
  endfunction
  task automatic pin(input logic v);
    @(posedge clk) wp_n <= v;
    repeat (5) @(posedge clk);
    #1 chk({7'h0, hw_lock}, {7'h0, ~v});
  endtask
  initial begin
    rst <= 1'b1;
    void'($urandom(44));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_st(); chk(s, 8'h00);
    fr(40'hff06, 16); rd_st(); chk(s, 8'h00);
    fr(40'h06, 8); secp_spi_master_inst.xfer(40'h05_0000, 24, s); chk(s, 8'h02);
    fr(40'h04, 8); rd_st(); chk(s, 8'h00);
    fr(40'h010c, 16); rd_st(); chk(s, 8'h00);
    e = 8'h00;
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom) & 8'h7f;
      d[3:2] = 2'(k);
      status_update_cmd(d);
      fr(40'h04, 8);
      rd_st(); chk(s, e | 8'h03);
      wait_idle();
      e = {4'h0, d[3:2], 2'h0};
      chk(s, e);
      chk(st, e);
      chk({7'h0, busy}, 8'h00);
      for (int j = 0; j < 2; j++) begin
        a = j ? {2'h3, 15'($urandom)} : 17'($urandom);
        p = prot(2'(k), a);
        g = n_go;
        r = n_ref;
        fr(40'h06, 8);
        fr({8'h02, 7'h0, a, 8'($urandom)}, 40);
        wait_idle();
        chk(8'(n_go - g), {7'h0, ~p});
        chk(8'(n_ref - r), {7'h0, p});
        if (!p) chk(aw.addr[7:0], a[7:0]);
        if (!p) chk(8'(aw.addr >> 9), 8'(a >> 9));
      end
    end
    secp_spi_master_inst.cpol = 1'b1;
    status_update_cmd(8'h80); wait_idle(); chk(s, 8'h80);
    pin(1'b0);
    status_update_cmd(8'h0c); rd_st(); chk(s, 8'h82);
    pin(1'b1);
    status_update_cmd(8'h04); wait_idle(); chk(s, 8'h04);
    fr(40'h06, 8); fr(40'h0210, 17); rd_st(); chk(s, 8'h06);
    g = n_rg;
    fr(40'h03_0000_0000, 40); chk(8'(n_rg - g), 8'h01);
    give_verdict();
  end
endmodule
bind secp_core secp_core_properties #(.WRITE_CYCLES(WRITE_CYCLES)) secp_core_properties_inst (
  .clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_miso_oe_n(spi_miso_oe_n), .wp_n(wp_n),
  .array_write(array_write), .write_done(write_done), .busy(busy), .hw_lock(hw_lock),
  .status_out(status_out), .cmd_refused(cmd_refused));
`default_nettype wire
